/* File: src/unvs_pkg.sv */
// Types for the user non-volatile register store.
// Assumes unvs_regs.svh is reachable on the include path.
`include "unvs_regs.svh"
package unvs_pkg;
  typedef enum logic [1:0] {
    UNVS_IDLE = 2'b00,
    UNVS_WRITE = 2'b01,
    UNVS_DONE = 2'b10
  } unvs_state_e;
  typedef logic [`UNVS_DATA_W-1:0] unvs_word_t;
endpackage : unvs_pkg

/* File: src/unvs_range.sv */
// Entry number selector and range check.
// Assumes inputs come from logic on the same clock.
`timescale 1ns/1ns
`include "unvs_regs.svh"
module unvs_range #(
  parameter int ENTRIES = `UNVS_ENTRIES_SMALL,
  parameter int IW = 6
) (
  // Entry number sources
  input wire logic use_indirect,
  input wire logic [`UNVS_NUM_W-1:0] const_num,
  input wire logic [`UNVS_NUM_W-1:0] reg_num,
  // Result
  output logic valid,
  output logic [IW-1:0] index
);
  logic [`UNVS_NUM_W-1:0] num;
  logic [`UNVS_NUM_W-1:0] off;
  always_comb begin
    num = use_indirect ? reg_num : const_num;
    off = num - `UNVS_FIRST_ENTRY;
    valid = (num >= `UNVS_FIRST_ENTRY) && (off < ENTRIES[`UNVS_NUM_W-1:0]);
    index = off[IW-1:0];
  end
endmodule : unvs_range

/* File: src/unvs_regs.svh */
// Constants for the user non-volatile register store.
// Assumes a 50 MHz system clock; included by the package and the modules.
`ifndef UNVS_REGS_SVH
`define UNVS_REGS_SVH
`define UNVS_FIRST_ENTRY 16'h07D0
`define UNVS_ENTRIES_SMALL 5
`define UNVS_ENTRIES_LARGE 50
`define UNVS_DATA_W 32
`define UNVS_NUM_W 16
`define UNVS_CLK_HZ 50000000
`define UNVS_WRITE_MS 20
`define UNVS_WRITE_CYCLES ((`UNVS_CLK_HZ / 1000) * `UNVS_WRITE_MS)
`endif

/* File: src/unvs_store.sv */
// User non-volatile register store with slow, stalling writes.
// Assumes commands come from processor logic on the same clock.
// The bank is written only through the slow sequencer; reads answer in one cycle.
`timescale 1ns/1ns
`include "unvs_regs.svh"
module unvs_store
  import unvs_pkg::*;
#(
  parameter int ENTRIES = `UNVS_ENTRIES_SMALL,
  parameter int WRITE_CYCLES = `UNVS_WRITE_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  // Command
  input wire logic system_read_command,
  input wire logic system_write_command,
  input wire logic use_indirect,
  input wire logic [`UNVS_NUM_W-1:0] const_num,
  input wire logic [`UNVS_NUM_W-1:0] reg_num,
  input wire logic [`UNVS_DATA_W-1:0] write_data,
  // Answer
  output logic busy,
  output logic done,
  output logic rd_valid,
  output logic [`UNVS_DATA_W-1:0] rd_data,
  output logic rejected
);
  localparam int IW = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;
  localparam int CW = $clog2(WRITE_CYCLES + 1);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Held apart from any working register file; no reset, as it models cells.
  unvs_word_t mem [ENTRIES];

  // ----------------------------------------------------------------
  // Entry number check
  // ----------------------------------------------------------------
  // valid is low for any number outside the bank, whichever source gave it.
  logic valid;
  logic [IW-1:0] index;
  unvs_range #(.ENTRIES(ENTRIES), .IW(IW)) u_range (
    .use_indirect(use_indirect),
    .const_num(const_num),
    .reg_num(reg_num),
    .valid(valid),
    .index(index)
  );

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  // The sequencer owns the slow write: it latches the entry and the word when
  // a write is taken and keeps the bank busy until the cells are programmed.
  unvs_state_e state;
  unvs_state_e next_state;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic [IW-1:0] wr_index;
  logic [IW-1:0] next_wr_index;
  unvs_word_t wr_word;
  unvs_word_t next_wr_word;
  logic mem_we;
  logic timer_zero;

  // ----------------------------------------------------------------
  // Answer state
  // ----------------------------------------------------------------
  logic next_busy;
  logic next_done;
  logic next_rd_valid;
  unvs_word_t next_rd_data;
  logic next_rejected;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // Commands are looked at only while idle; one that arrives during a write
  // is dropped rather than queued, so the caller must wait for done.
  logic idle;
  logic take_write;
  logic take_read;

  always_comb begin
    idle = (state == UNVS_IDLE);
    // Write wins when both strobes are high in the same cycle.
    take_write = idle && system_write_command;
    take_read = idle && system_read_command && !system_write_command;
  end

  // ----------------------------------------------------------------
  // Programming timer
  // ----------------------------------------------------------------
  // Loaded when a write is taken and run down while the sequencer waits; it
  // stops with everything else while clk_en is low.
  always_comb begin
    timer_zero = (count == '0);
    next_count = count;
    if (take_write && valid) begin
      next_count = CW'(WRITE_CYCLES - 1);
    end else if ((state == UNVS_WRITE) && !timer_zero) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (clk_en) begin
      count <= next_count;
    end
  end

  // ----------------------------------------------------------------
  // Write sequencer
  // ----------------------------------------------------------------
  // The cells are touched only once the full programming time has passed, so a
  // write looks atomic to any later read.
  always_comb begin
    next_state = state;
    next_wr_index = wr_index;
    next_wr_word = wr_word;
    mem_we = 1'b0;
    case (state)
      UNVS_IDLE: begin
        if (take_write && valid) begin
          next_state = UNVS_WRITE;
          next_wr_index = index;
          next_wr_word = write_data;
        end
      end
      UNVS_WRITE: begin
        if (timer_zero) begin
          mem_we = 1'b1;
          next_state = UNVS_DONE;
        end
      end
      default: begin
        next_state = UNVS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= UNVS_IDLE;
      wr_index <= '0;
      wr_word <= '0;
    end else if (clk_en) begin
      state <= next_state;
      wr_index <= next_wr_index;
      wr_word <= next_wr_word;
    end
  end

  // ----------------------------------------------------------------
  // Answer
  // ----------------------------------------------------------------
  // Every output is a register. done, rd_valid and rejected are one-cycle
  // pulses; rd_data holds the last good read until the next one.
  always_comb begin
    next_busy = busy;
    next_done = 1'b0;
    next_rd_valid = 1'b0;
    next_rd_data = rd_data;
    next_rejected = 1'b0;
    case (state)
      UNVS_IDLE: begin
        if (take_write) begin
          if (valid) begin
            next_busy = 1'b1;
          end else begin
            next_rejected = 1'b1;
            next_done = 1'b1;
          end
        end else if (take_read) begin
          if (valid) begin
            next_rd_data = mem[index];
            next_rd_valid = 1'b1;
          end else begin
            next_rejected = 1'b1;
          end
          next_done = 1'b1;
        end
      end
      UNVS_WRITE: begin
        next_busy = 1'b1;
      end
      default: begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      done <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= '0;
      rejected <= 1'b0;
    end else if (clk_en) begin
      busy <= next_busy;
      done <= next_done;
      rd_valid <= next_rd_valid;
      rd_data <= next_rd_data;
      rejected <= next_rejected;
    end
  end

  // ----------------------------------------------------------------
  // Storage write port
  // ----------------------------------------------------------------
  // No reset here: the cells keep their content across a reset, as they
  // would across a power loss.
  always_ff @(posedge clock) begin
    if (clk_en && mem_we) begin
      mem[wr_index] <= wr_word;
    end
  end
endmodule : unvs_store

/* File: tb/testbench.sv */
// Bench for unvs_store driven through the processor model.
`timescale 1ns/1ns
module testbench;
  logic clock = 0, rst = 1, clk_en = 1, ok;
  logic system_read_command, system_write_command, use_indirect;
  logic busy, done, rd_valid, rejected;
  logic [15:0] const_num, reg_num;
  logic [31:0] write_data, rd_data;
  int num_errors = 0, checks_done = 0;
  initial forever #10 clock = ~clock;
  unvs_store #(.ENTRIES(5), .WRITE_CYCLES(8)) dut_u (.*);
  unvs_cpu_model cpu_u (.*);
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic cmd(input logic w, i, input logic [15:0] n, input logic [31:0] d);
    cpu_u.op(w, i, n, d, ok);
    if (ok !== 1'h1) begin
      num_errors++;
      $display("[FAIL] done expected 1 seen %b", ok);
      report_and_stop();
    end
  endtask : cmd
  task automatic sc_rw;
    cmd(1'h1, 1'h0, 16'h07D0, 32'hA5C30F01);
    chk("busy", 1'h0, busy);
    cmd(1'h1, 1'h1, 16'h07D4, 32'h5A3CF0FE);
    cmd(1'h0, 1'h1, 16'h07D0, 32'h0);
    chk("rd 2000", 32'hA5C30F01, rd_data);
    chk("rd_valid 2000", 1'h1, rd_valid);
    cmd(1'h0, 1'h0, 16'h07D4, 32'h0);
    chk("rd 2004", 32'h5A3CF0FE, rd_data);
  endtask : sc_rw
  task automatic sc_hold;
    fork
      cmd(1'h1, 1'h0, 16'h07D1, 32'h0F1E2D3C);
      begin
        repeat (4) @(posedge clock);
        clk_en <= 1'h0;
        repeat (5) @(posedge clock);
        clk_en <= 1'h1;
        repeat (2) @(posedge clock);
        #1 chk("busy frozen", 1'h1, busy);
        cpu_u.pulse(1'h1, 16'h07D1, 32'hC3D2E1F0);
        #1 chk("busy", 1'h1, busy);
      end
    join
    chk("done", 1'h1, done);
    cmd(1'h0, 1'h0, 16'h07D1, 32'h0);
    chk("rd 2001", 32'h0F1E2D3C, rd_data);
  endtask : sc_hold
  task automatic sc_bad;
    cmd(1'h1, 1'h0, 16'h07D5, 32'h1);
    chk("reject", 1'h1, rejected);
    cmd(1'h0, 1'h1, 16'h07CF, 32'h0);
    chk("rd_valid", 1'h0, rd_valid);
    @(posedge clock);
    rst <= 1'h1;
    @(posedge clock);
    rst <= 1'h0;
    cmd(1'h0, 1'h0, 16'h07D4, 32'h0);
    chk("kept", 32'h5A3CF0FE, rd_data);
  endtask : sc_bad
  task automatic report_and_stop;
    if (num_errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'h0;
    sc_rw();
    sc_hold();
    sc_bad();
    report_and_stop();
  end
endmodule : testbench

/* File: tb/unvs_cpu_model.sv */
// Processor model issuing one command at a time to the store.
`timescale 1ns/1ns
module unvs_cpu_model (
  input wire logic clock,
  input wire logic done,
  output logic system_read_command = 1'h0,
  output logic system_write_command = 1'h0,
  output logic use_indirect = 1'h0,
  output logic [15:0] const_num = 16'h0,
  output logic [15:0] reg_num = 16'h0,
  output logic [31:0] write_data = 32'h0
);
  task automatic op(input logic w, i, input logic [15:0] n, input logic [31:0] d,
    output logic ok);
    @(posedge clock);
    system_read_command <= !w;
    system_write_command <= w;
    use_indirect <= i;
    const_num <= i ? ~n : n;
    reg_num <= i ? n : ~n;
    write_data <= d;
    @(posedge clock);
    system_read_command <= 1'h0;
    system_write_command <= 1'h0;
    write_data <= ~d;
    ok = 1'h0;
    for (int k = 0; k < 20 && !ok; k++) begin
      #1 ok = done;
      if (!ok) @(posedge clock);
    end
  endtask : op
  task automatic pulse(input logic w, input logic [15:0] n, input logic [31:0] d);
    @(posedge clock);
    system_read_command <= !w;
    system_write_command <= w;
    use_indirect <= 1'h0;
    const_num <= n;
    write_data <= d;
    @(posedge clock);
    system_read_command <= 1'h0;
    system_write_command <= 1'h0;
  endtask : pulse
endmodule : unvs_cpu_model

/* File: tb/unvs_store_asserts.sv */
// Checker for unvs_store, bound to its ports.
// Assumes one clock and an async active-high reset.
`timescale 1ns/1ns
module unvs_store_asserts #(
  parameter int ENTRIES = 5,
  parameter int WRITE_CYCLES = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic system_read_command,
  input wire logic system_write_command,
  input wire logic use_indirect,
  input wire logic [15:0] const_num,
  input wire logic [15:0] reg_num,
  input wire logic busy,
  input wire logic done,
  input wire logic rd_valid,
  input wire logic [31:0] rd_data,
  input wire logic rejected
);
  logic [15:0] n;
  logic acc, ok;
  int bc, next_bc;
  always_comb begin
    n = use_indirect ? reg_num : const_num;
    ok = n >= 16'h07D0 && n < 16'h07D0 + ENTRIES;
    acc = clk_en && !busy;
    next_bc = !clk_en ? bc : (busy ? bc + 1 : 0);
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bc <= 0;
    end else begin
      bc <= next_bc;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_take;
    acc && ok;
  endsequence
  AST_RD: assert property (
    s_take ##0 (system_read_command && !system_write_command) |=> done && rd_valid
    && !rejected) else $error("read answer wrong");
  AST_BAD: assert property (
    acc && !ok && (system_read_command || system_write_command) |=> done
    && rejected && !rd_valid && !busy) else $error("bad number taken");
  AST_WR_BUSY: assert property (
    s_take ##0 system_write_command |=> busy && !done) else $error("no busy");
  AST_WR_LEN: assert property (
    $fell(busy) |-> done && bc == WRITE_CYCLES + 1) else $error("write length");
  AST_WR_TIME: assert property (
    busy |-> bc <= WRITE_CYCLES) else $error("write too long");
  AST_IN_WRITE: assert property (
    busy |-> !done && !rd_valid && !rejected) else $error("answer while busy");
  AST_RD_PULSE: assert property (
    rd_valid |-> done && !busy && !rejected) else $error("read pulse");
  AST_RD_HOLD: assert property (
    !rd_valid |-> $stable(rd_data)) else $error("read data moved");
endmodule : unvs_store_asserts
bind unvs_store unvs_store_asserts #(.ENTRIES(ENTRIES), .WRITE_CYCLES(WRITE_CYCLES)) chk_u (.*);
